// [common/nfqm_consts.svh]
`ifndef NFQM_CONSTS_SVH
`define NFQM_CONSTS_SVH

// Register byte offsets
`define NFQM_OFF_DEV_FEAT 8'h00
`define NFQM_OFF_DRV_FEAT 8'h04
`define NFQM_OFF_CTRL 8'h08
`define NFQM_OFF_STAT 8'h0C
`define NFQM_OFF_VIOL 8'h10
`define NFQM_OFF_NEG_FEAT 8'h14
`define NFQM_OFF_QPAIRS 8'h18
`define NFQM_OFF_CTRLQ_IDX 8'h1C
`define NFQM_OFF_LINK_STAT 8'h20
`define NFQM_OFF_MAX_PAIRS 8'h24
`define NFQM_OFF_QUERY 8'h28

// Control register fields
`define NFQM_CTRL_COMMIT 0
`define NFQM_CTRL_LEGACY 1
`define NFQM_CTRL_CLEAR 2

// Status register fields
`define NFQM_STAT_NEGOTIATED 0
`define NFQM_STAT_ERROR 1
`define NFQM_STAT_CTRLQ 2
`define NFQM_STAT_MQ 3

// Link status field values
`define NFQM_LINK_UP 16'h0001
`define NFQM_ANNOUNCE 16'h0002

// Feature positions
`define NFQM_F_CSUM 0
`define NFQM_F_GUEST_CSUM 1
`define NFQM_F_CTRL_OFFLOADS 2
`define NFQM_F_STATION_ADDR 5
`define NFQM_F_ANY_GSO 6
`define NFQM_F_GUEST_TSO4 7
`define NFQM_F_GUEST_TSO6 8
`define NFQM_F_GUEST_ECN 9
`define NFQM_F_GUEST_UFO 10
`define NFQM_F_HOST_TSO4 11
`define NFQM_F_HOST_TSO6 12
`define NFQM_F_HOST_ECN 13
`define NFQM_F_HOST_UFO 14
`define NFQM_F_MRG_RX 15
`define NFQM_F_LINK_STATUS 16
`define NFQM_F_CTRL_QUEUE 17
`define NFQM_F_CTRL_RX 18
`define NFQM_F_CTRL_VLAN 19
`define NFQM_F_ANNOUNCE 21
`define NFQM_F_MULTI_QUEUE 22
`define NFQM_F_CTRL_ADDR 23

// Query register fields
`define NFQM_QRY_KIND_LSB 16
`define NFQM_QRY_KIND_MSB 17

// Queue-pair limits, control-queue offset and reset values
`define NFQM_PAIRS_MIN 16'h0001
`define NFQM_PAIRS_MAX 16'h8000
`define NFQM_RST_WORD 32'h0000_0000
`define NFQM_CTRLQ_OFS 17'h0_0002
`define NFQM_RST_CTRLQ_IDX 17'h0_0004

// Link status write field
`define NFQM_LINK_ANN_CLR 1

`endif

// [common/nfqm_pkg.sv]
package nfqm_pkg;

    typedef struct packed {
        logic ctrl_addr;
        logic multi_queue;
        logic announce;
        logic ctrl_vlan;
        logic ctrl_rx;
        logic ctrl_queue_present;
        logic link_status;
        logic merged_rx_buffers;
        logic host_ufo;
        logic host_ecn;
        logic host_tso6;
        logic host_tso4;
        logic guest_ufo;
        logic guest_ecn;
        logic guest_tso6;
        logic guest_tso4;
        logic any_gso;
        logic station_addr;
        logic ctrl_offloads;
        logic guest_csum;
        logic csum;
    } nfqm_feat_t;

    typedef enum logic [1:0] {
        NFQM_Q_NONE,
        NFQM_Q_RX,
        NFQM_Q_TX,
        NFQM_Q_CTRL
    } nfqm_qkind_t;

    typedef struct packed {
        nfqm_qkind_t kind;
        logic [15:0] pair;
    } nfqm_qinfo_t;

    typedef enum {
        NFQM_ST_OPEN,
        NFQM_ST_DONE
    } nfqm_state_t;

endpackage : nfqm_pkg

// [hw/nfqm_dep_check.sv]
`include "nfqm_consts.svh"

module nfqm_dep_check
    import nfqm_pkg::*;
(
    // Candidate feature set
    input wire logic [31:0] feat_in,
    input wire logic legacy,
    // Filtered result
    output nfqm_feat_t feat_out,
    output logic [31:0] viol,
    output logic err
);

    logic [31:0] f;

    always_comb begin
        f = feat_in;
        viol = `NFQM_RST_WORD;
        // Bit 6 has meaning only in legacy operation
        if (!legacy) begin
            f[`NFQM_F_ANY_GSO] = 1'b0;
        end
        if (!f[`NFQM_F_GUEST_CSUM]) begin
            viol[`NFQM_F_GUEST_TSO4] = f[`NFQM_F_GUEST_TSO4];
            viol[`NFQM_F_GUEST_TSO6] = f[`NFQM_F_GUEST_TSO6];
            viol[`NFQM_F_GUEST_UFO] = f[`NFQM_F_GUEST_UFO];
        end
        if (!f[`NFQM_F_CSUM]) begin
            viol[`NFQM_F_HOST_TSO4] = f[`NFQM_F_HOST_TSO4];
            viol[`NFQM_F_HOST_TSO6] = f[`NFQM_F_HOST_TSO6];
            viol[`NFQM_F_HOST_UFO] = f[`NFQM_F_HOST_UFO];
        end
        f = f & ~viol;
        // ECN judged against segmentation that survived its own check
        if (!f[`NFQM_F_GUEST_TSO4] && !f[`NFQM_F_GUEST_TSO6]) begin
            viol[`NFQM_F_GUEST_ECN] = f[`NFQM_F_GUEST_ECN];
        end
        if (!f[`NFQM_F_HOST_TSO4] && !f[`NFQM_F_HOST_TSO6]) begin
            viol[`NFQM_F_HOST_ECN] = f[`NFQM_F_HOST_ECN];
        end
        if (!f[`NFQM_F_CTRL_QUEUE]) begin
            viol[`NFQM_F_CTRL_RX] = f[`NFQM_F_CTRL_RX];
            viol[`NFQM_F_CTRL_VLAN] = f[`NFQM_F_CTRL_VLAN];
            viol[`NFQM_F_ANNOUNCE] = f[`NFQM_F_ANNOUNCE];
            viol[`NFQM_F_MULTI_QUEUE] = f[`NFQM_F_MULTI_QUEUE];
            viol[`NFQM_F_CTRL_ADDR] = f[`NFQM_F_CTRL_ADDR];
        end
        f = f & ~viol;
        err = |viol;
    end

    always_comb begin
        feat_out.csum = f[`NFQM_F_CSUM];
        feat_out.guest_csum = f[`NFQM_F_GUEST_CSUM];
        feat_out.ctrl_offloads = f[`NFQM_F_CTRL_OFFLOADS];
        feat_out.station_addr = f[`NFQM_F_STATION_ADDR];
        feat_out.any_gso = f[`NFQM_F_ANY_GSO];
        feat_out.guest_tso4 = f[`NFQM_F_GUEST_TSO4];
        feat_out.guest_tso6 = f[`NFQM_F_GUEST_TSO6];
        feat_out.guest_ecn = f[`NFQM_F_GUEST_ECN];
        feat_out.guest_ufo = f[`NFQM_F_GUEST_UFO];
        feat_out.host_tso4 = f[`NFQM_F_HOST_TSO4];
        feat_out.host_tso6 = f[`NFQM_F_HOST_TSO6];
        feat_out.host_ecn = f[`NFQM_F_HOST_ECN];
        feat_out.host_ufo = f[`NFQM_F_HOST_UFO];
        feat_out.merged_rx_buffers = f[`NFQM_F_MRG_RX];
        feat_out.link_status = f[`NFQM_F_LINK_STATUS];
        feat_out.ctrl_queue_present = f[`NFQM_F_CTRL_QUEUE];
        feat_out.ctrl_rx = f[`NFQM_F_CTRL_RX];
        feat_out.ctrl_vlan = f[`NFQM_F_CTRL_VLAN];
        feat_out.announce = f[`NFQM_F_ANNOUNCE];
        feat_out.multi_queue = f[`NFQM_F_MULTI_QUEUE];
        feat_out.ctrl_addr = f[`NFQM_F_CTRL_ADDR];
    end

endmodule : nfqm_dep_check

// [hw/nfqm_top.sv]
// Strobed register access and the address map were left to the implementer.
`include "nfqm_consts.svh"

module nfqm_top
    import nfqm_pkg::*;
#(
    parameter logic [31:0] DEV_FEATURES = 32'h00EF_FFE7,
    parameter int MAX_PAIRS = 1
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // Register port
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    // Link events from the network side
    input wire logic link_up,
    input wire logic announce_req,
    // Queue lookup from the datapath
    input wire logic [16:0] q_index,
    output nfqm_qinfo_t q_info,
    // Negotiation results
    output nfqm_feat_t feat,
    output logic negotiated,
    output logic neg_error,
    output logic [15:0] rx_queue_n,
    output logic [15:0] tx_queue_n,
    output logic ctrl_queue_present,
    output logic [16:0] ctrl_queue_idx
);

    // Offered pair count forced into the legal window
    localparam logic [15:0] PAIRS_CLAMP =
        (MAX_PAIRS < int'(`NFQM_PAIRS_MIN)) ? `NFQM_PAIRS_MIN :
        (MAX_PAIRS > int'(`NFQM_PAIRS_MAX)) ? `NFQM_PAIRS_MAX : 16'(MAX_PAIRS);
    localparam logic PAIRS_OK = (MAX_PAIRS >= int'(`NFQM_PAIRS_MIN)) &&
                                (MAX_PAIRS <= int'(`NFQM_PAIRS_MAX));

    logic [31:0] dev_feat;
    logic [31:0] drv_feat_r;
    logic legacy_r;
    nfqm_state_t state_r;
    logic error_r;
    logic [31:0] viol_r;
    logic [31:0] neg_word_r;
    nfqm_feat_t feat_r;
    logic [15:0] pairs_r;
    logic [16:0] ctrl_idx_r;
    logic announce_r;
    logic [16:0] query_idx_r;
    logic [31:0] rdata_r;

    nfqm_feat_t chk_feat;
    logic [31:0] chk_viol;
    logic chk_err;
    logic [15:0] pairs_nxt;
    logic [31:0] chk_word;
    nfqm_qinfo_t qry_info;
    logic commit;
    logic clear;

    function automatic logic hit(input logic [7:0] addr, input logic [7:0] off);
        hit = (addr == off);
    endfunction : hit

    // Map a queue index onto its role and 1-based pair number
    function automatic nfqm_qinfo_t classify(input logic [16:0] idx, input logic [15:0] n,
                                             input logic cq, input logic [16:0] cidx);
        nfqm_qinfo_t r;
        r.kind = NFQM_Q_NONE;
        r.pair = 16'h0000;
        if (idx < {n, 1'b0}) begin
            r.kind = idx[0] ? NFQM_Q_TX : NFQM_Q_RX;
            r.pair = 16'(idx[16:1] + 16'h0001);
        end else if (cq && idx == cidx) begin
            r.kind = NFQM_Q_CTRL;
        end
        classify = r;
    endfunction : classify

    // Multiqueue is withdrawn from the offer when the pair count is illegal
    always_comb begin
        dev_feat = DEV_FEATURES;
        if (!PAIRS_OK) begin
            dev_feat[`NFQM_F_MULTI_QUEUE] = 1'b0;
        end
    end

    // Accepted bits the device never offered are dropped before checking
    nfqm_dep_check u_dep_check (
        .feat_in(drv_feat_r & dev_feat),
        .legacy(legacy_r),
        .feat_out(chk_feat),
        .viol(chk_viol),
        .err(chk_err)
    );

    assign commit = reg_wr && hit(reg_addr, `NFQM_OFF_CTRL) &&
                    reg_wdata[`NFQM_CTRL_COMMIT];
    assign clear = reg_wr && hit(reg_addr, `NFQM_OFF_CTRL) &&
                   reg_wdata[`NFQM_CTRL_CLEAR];

    always_comb begin
        pairs_nxt = `NFQM_PAIRS_MIN;
        if (chk_feat.multi_queue) begin
            pairs_nxt = PAIRS_CLAMP;
        end
    end

    // Final word; the legacy-only bit is dropped outside legacy operation
    always_comb begin
        chk_word = (drv_feat_r & dev_feat) & ~chk_viol;
        if (!legacy_r) begin
            chk_word[`NFQM_F_ANY_GSO] = 1'b0;
        end
    end

    assign qry_info = classify(query_idx_r, pairs_r, feat_r.ctrl_queue_present, ctrl_idx_r);

    // Accepted feature word, frozen once negotiation completes
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            drv_feat_r <= `NFQM_RST_WORD;
        end else if (reg_wr && hit(reg_addr, `NFQM_OFF_DRV_FEAT) && state_r == NFQM_ST_OPEN) begin
            drv_feat_r <= reg_wdata;
        end else if (clear) begin
            drv_feat_r <= `NFQM_RST_WORD;
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            legacy_r <= 1'b0;
        end else if (reg_wr && hit(reg_addr, `NFQM_OFF_CTRL) && state_r == NFQM_ST_OPEN) begin
            legacy_r <= reg_wdata[`NFQM_CTRL_LEGACY];
        end
    end

    // Negotiation state
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            state_r <= NFQM_ST_OPEN;
        end else begin
            unique case (state_r)
                NFQM_ST_OPEN: begin
                    if (commit && !clear) begin
                        state_r <= NFQM_ST_DONE;
                    end
                end
                NFQM_ST_DONE: begin
                    if (clear) begin
                        state_r <= NFQM_ST_OPEN;
                    end
                end
            endcase
        end
    end

    // Result capture at commit
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            feat_r <= '0;
            neg_word_r <= `NFQM_RST_WORD;
            viol_r <= `NFQM_RST_WORD;
            error_r <= 1'b0;
        end else if (clear) begin
            feat_r <= '0;
            neg_word_r <= `NFQM_RST_WORD;
            viol_r <= `NFQM_RST_WORD;
            error_r <= 1'b0;
        end else if (commit && state_r == NFQM_ST_OPEN) begin
            feat_r <= chk_feat;
            neg_word_r <= chk_word;
            viol_r <= chk_viol;
            error_r <= chk_err;
        end
    end

    // Queue layout capture at commit
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            pairs_r <= `NFQM_PAIRS_MIN;
            ctrl_idx_r <= `NFQM_RST_CTRLQ_IDX;
        end else if (clear) begin
            pairs_r <= `NFQM_PAIRS_MIN;
            ctrl_idx_r <= `NFQM_RST_CTRLQ_IDX;
        end else if (commit && state_r == NFQM_ST_OPEN) begin
            pairs_r <= pairs_nxt;
            ctrl_idx_r <= {pairs_nxt, 1'b0} + `NFQM_CTRLQ_OFS;
        end
    end

    // Announcement request, sticky; a new request beats a clear
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            announce_r <= 1'b0;
        end else if (announce_req) begin
            announce_r <= 1'b1;
        end else if (reg_wr && hit(reg_addr, `NFQM_OFF_LINK_STAT) &&
                     reg_wdata[`NFQM_LINK_ANN_CLR]) begin
            announce_r <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            query_idx_r <= 17'h0_0000;
        end else if (reg_wr && hit(reg_addr, `NFQM_OFF_QUERY)) begin
            query_idx_r <= reg_wdata[16:0];
        end
    end

    // Read data, valid the cycle after the strobe
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            rdata_r <= `NFQM_RST_WORD;
        end else if (reg_rd) begin
            rdata_r <= `NFQM_RST_WORD;
            if (hit(reg_addr, `NFQM_OFF_DEV_FEAT)) begin
                rdata_r <= dev_feat;
            end
            if (hit(reg_addr, `NFQM_OFF_DRV_FEAT)) begin
                rdata_r <= drv_feat_r;
            end
            if (hit(reg_addr, `NFQM_OFF_CTRL)) begin
                rdata_r[`NFQM_CTRL_LEGACY] <= legacy_r;
            end
            if (hit(reg_addr, `NFQM_OFF_STAT)) begin
                rdata_r[`NFQM_STAT_NEGOTIATED] <= (state_r == NFQM_ST_DONE);
                rdata_r[`NFQM_STAT_ERROR] <= error_r;
                rdata_r[`NFQM_STAT_CTRLQ] <= feat_r.ctrl_queue_present;
                rdata_r[`NFQM_STAT_MQ] <= feat_r.multi_queue;
            end
            if (hit(reg_addr, `NFQM_OFF_VIOL)) begin
                rdata_r <= viol_r;
            end
            if (hit(reg_addr, `NFQM_OFF_NEG_FEAT)) begin
                rdata_r <= neg_word_r;
            end
            if (hit(reg_addr, `NFQM_OFF_QPAIRS)) begin
                rdata_r[15:0] <= pairs_r;
            end
            if (hit(reg_addr, `NFQM_OFF_CTRLQ_IDX)) begin
                rdata_r[16:0] <= ctrl_idx_r;
            end
            if (hit(reg_addr, `NFQM_OFF_LINK_STAT)) begin
                rdata_r[15:0] <= (link_up ? `NFQM_LINK_UP : 16'h0000) |
                                 (announce_r ? `NFQM_ANNOUNCE : 16'h0000);
            end
            if (hit(reg_addr, `NFQM_OFF_MAX_PAIRS)) begin
                rdata_r[15:0] <= PAIRS_CLAMP;
            end
            if (hit(reg_addr, `NFQM_OFF_QUERY)) begin
                rdata_r[`NFQM_QRY_KIND_MSB:`NFQM_QRY_KIND_LSB] <= qry_info.kind;
                rdata_r[15:0] <= qry_info.pair;
            end
        end
    end

    // Datapath queue lookup
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            q_info <= '0;
        end else begin
            q_info <= classify(q_index, pairs_r, feat_r.ctrl_queue_present, ctrl_idx_r);
        end
    end

    assign reg_rdata = rdata_r;
    assign feat = feat_r;
    assign negotiated = (state_r == NFQM_ST_DONE);
    assign neg_error = error_r;
    assign rx_queue_n = pairs_r;
    assign tx_queue_n = pairs_r;
    assign ctrl_queue_present = feat_r.ctrl_queue_present;
    assign ctrl_queue_idx = ctrl_idx_r;

endmodule : nfqm_top

// [verif/nfqm_top_sva.sv]
`include "nfqm_consts.svh"

module nfqm_top_sva
    import nfqm_pkg::*;
#(
    parameter int MAX_PAIRS = 1
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // Register port
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [31:0] reg_rdata,
    // Link and lookup
    input wire logic link_up,
    input wire logic announce_req,
    input wire logic [16:0] q_index,
    input wire nfqm_qinfo_t q_info,
    // Results
    input wire nfqm_feat_t feat,
    input wire logic negotiated,
    input wire logic neg_error,
    input wire logic [15:0] rx_queue_n,
    input wire logic [15:0] tx_queue_n,
    input wire logic ctrl_queue_present,
    input wire logic [16:0] ctrl_queue_idx
);
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (rst);

    property p_rx_even;
        !$past(rst) && !$past(q_index[0]) && $past(q_index) < {$past(rx_queue_n), 1'h0}
            |-> q_info.kind == NFQM_Q_RX && q_info.pair == $past(q_index[16:1]) + 16'h0001;
    endproperty
    a_rx_even: assert property (p_rx_even) else $error("rx lookup wrong");
    property p_tx_odd;
        !$past(rst) && $past(q_index[0]) && $past(q_index) < {$past(tx_queue_n), 1'h0}
            |-> q_info.kind == NFQM_Q_TX && q_info.pair == $past(q_index[16:1]) + 16'h0001;
    endproperty
    a_tx_odd: assert property (p_tx_odd) else $error("tx lookup wrong");
    property p_ctrl_lookup;
        !$past(rst) && $past(q_index) == $past(ctrl_queue_idx) |-> q_info.pair == 16'h0000
            && q_info.kind == ($past(ctrl_queue_present) ? NFQM_Q_CTRL : NFQM_Q_NONE);
    endproperty
    a_ctrl_lookup: assert property (p_ctrl_lookup) else $error("ctrl lookup wrong");
    property p_ctrl_idx;
        ctrl_queue_idx == {rx_queue_n, 1'h0} + 17'h0_0002;
    endproperty
    a_ctrl_idx: assert property (p_ctrl_idx) else $error("ctrl index wrong");
    property p_pairs;
        rx_queue_n == tx_queue_n
            && rx_queue_n == (feat.multi_queue ? 16'(MAX_PAIRS) : 16'h0001);
    endproperty
    a_pairs: assert property (p_pairs) else $error("pair count wrong");
    property p_cq;
        ctrl_queue_present == feat.ctrl_queue_present;
    endproperty
    a_cq: assert property (p_cq) else $error("ctrl queue flag wrong");
    property p_guest_csum;
        feat.guest_tso4 || feat.guest_tso6 || feat.guest_ufo |-> feat.guest_csum;
    endproperty
    a_guest_csum: assert property (p_guest_csum) else $error("guest csum dep");
    property p_guest_ecn;
        feat.guest_ecn |-> feat.guest_tso4 || feat.guest_tso6;
    endproperty
    a_guest_ecn: assert property (p_guest_ecn) else $error("guest ecn dep");
    property p_host_csum;
        feat.host_tso4 || feat.host_tso6 || feat.host_ufo |-> feat.csum;
    endproperty
    a_host_csum: assert property (p_host_csum) else $error("host csum dep");
    property p_host_ecn;
        feat.host_ecn |-> feat.host_tso4 || feat.host_tso6;
    endproperty
    a_host_ecn: assert property (p_host_ecn) else $error("host ecn dep");
    property p_ctrl_deps;
        feat.ctrl_rx || feat.ctrl_vlan || feat.announce || feat.multi_queue || feat.ctrl_addr
            |-> feat.ctrl_queue_present;
    endproperty
    a_ctrl_deps: assert property (p_ctrl_deps) else $error("ctrl queue dep");
    property p_link;
        !$past(rst) && $past(reg_rd) && $past(reg_addr) == `NFQM_OFF_LINK_STAT
            |-> reg_rdata[0] == $past(link_up);
    endproperty
    a_link: assert property (p_link) else $error("link bit wrong");
endmodule : nfqm_top_sva

bind nfqm_top nfqm_top_sva #(.MAX_PAIRS(MAX_PAIRS)) u_sva (
    .sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .link_up(link_up),
    .announce_req(announce_req), .q_index(q_index), .q_info(q_info), .feat(feat),
    .negotiated(negotiated), .neg_error(neg_error), .rx_queue_n(rx_queue_n),
    .tx_queue_n(tx_queue_n), .ctrl_queue_present(ctrl_queue_present),
    .ctrl_queue_idx(ctrl_queue_idx)
);

// [verif/nfqm_drv_model.sv]
module nfqm_drv_model (
    // Clock
    input wire logic sys_clk,
    // Register port
    output logic [7:0] reg_addr,
    output logic [31:0] reg_wdata,
    output logic reg_wr,
    output logic reg_rd,
    input wire logic [31:0] reg_rdata
);
    timeunit 1ns;
    timeprecision 1ns;

    initial begin
        reg_addr = 8'h00;
        reg_wdata = 32'h0;
        reg_wr = 1'h0;
        reg_rd = 1'h0;
    end

    // Released lines show the inverse, never the last value
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'h1;
        @(posedge sys_clk);
        reg_wr <= 1'h0;
        reg_addr <= ~a;
        reg_wdata <= ~d;
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd <= 1'h1;
        @(posedge sys_clk);
        reg_rd <= 1'h0;
        reg_addr <= ~a;
        #1;
        d = reg_rdata;
    endtask : rd

    // A well-behaved driver drops features whose prerequisites it lacks
    function automatic logic [31:0] lawful(input logic [31:0] w);
        if (!w[1]) {w[10], w[8], w[7]} = 3'h0;
        if (!(w[7] | w[8])) w[9] = 1'h0;
        if (!w[0]) {w[14], w[12], w[11]} = 3'h0;
        if (!(w[11] | w[12])) w[13] = 1'h0;
        if (!w[17]) {w[23:21], w[19:18]} = 5'h00;
        return w;
    endfunction : lawful
endmodule : nfqm_drv_model

// [verif/tb.sv]
`include "nfqm_consts.svh"

module tb
    import nfqm_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int MAXP = 4;
    localparam logic [31:0] DEVF = 32'h00EF_FFE7;
    logic sys_clk, rst, reg_wr, reg_rd, link_up, announce_req;
    logic negotiated, neg_error, ctrl_queue_present, legacy;
    logic [7:0] reg_addr;
    logic [31:0] reg_wdata, reg_rdata, rdv, word, neg, viol;
    logic [16:0] q_index, ctrl_queue_idx;
    logic [15:0] rx_queue_n, tx_queue_n, seed;
    nfqm_qinfo_t q_info;
    nfqm_feat_t feat;
    int num_errors = 0;
    int compares = 0;
    int cycles = 0;
    int n;
    logic [31:0] corners [6] = '{32'hFFFF_FFFF, 32'h0, 32'h0040_0000, 32'h0042_0000,
        32'h0000_0280, 32'h0000_2001};

    nfqm_top #(.DEV_FEATURES(DEVF), .MAX_PAIRS(MAXP)) DUT (
        .sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .link_up(link_up),
        .announce_req(announce_req), .q_index(q_index), .q_info(q_info), .feat(feat),
        .negotiated(negotiated), .neg_error(neg_error), .rx_queue_n(rx_queue_n),
        .tx_queue_n(tx_queue_n), .ctrl_queue_present(ctrl_queue_present),
        .ctrl_queue_idx(ctrl_queue_idx)
    );
    nfqm_drv_model drv (
        .sys_clk(sys_clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata)
    );

    initial begin
        sys_clk = 1'h0;
        forever #20 sys_clk = ~sys_clk;
    end

    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            num_errors++;
            results();
        end
    end

    task automatic results();
        if (num_errors == 0 && compares > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : results

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    function automatic logic [15:0] step(input logic [15:0] s);
        return s[0] ? (s >> 1) ^ 16'hB400 : s >> 1;
    endfunction : step

    // Returns dropped mask above the negotiated word
    function automatic logic [63:0] expect_neg(input logic [31:0] w, input logic lg);
        logic [31:0] a;
        logic [31:0] v;
        a = w & DEVF;
        a[6] = a[6] & lg;
        v = 32'h0;
        {v[10], v[8], v[7]} = {a[10], a[8], a[7]} & {3{~a[1]}};
        v[9] = a[9] & ~(a[1] & (a[7] | a[8]));
        {v[14], v[12], v[11]} = {a[14], a[12], a[11]} & {3{~a[0]}};
        v[13] = a[13] & ~(a[0] & (a[11] | a[12]));
        {v[23:21], v[19:18]} = {a[23:21], a[19:18]} & {5{~a[17]}};
        return {v, a & ~v};
    endfunction : expect_neg

    function automatic logic [31:0] exp_q(input int i, input int np, input logic cq);
        if (i < 2 * np) return {14'h0, i[0] ? NFQM_Q_TX : NFQM_Q_RX, 16'(i / 2 + 1)};
        if (i == 2 * np + 2 && cq) return {14'h0, NFQM_Q_CTRL, 16'h0000};
        return 32'h0;
    endfunction : exp_q

    task automatic negotiate(input logic [31:0] w, input logic lg);
        drv.wr(`NFQM_OFF_DRV_FEAT, w);
        drv.wr(`NFQM_OFF_CTRL, {30'h0, lg, 1'h0});
        drv.wr(`NFQM_OFF_CTRL, {30'h0, lg, 1'h1});
        {viol, neg} = expect_neg(w, lg);
        n = neg[22] ? MAXP : 1;
        drv.rd(`NFQM_OFF_VIOL, rdv);
        check("viol", rdv, viol);
        drv.rd(`NFQM_OFF_STAT, rdv);
        check("stat", rdv, {28'h0, neg[22], neg[17], viol != 32'h0, 1'h1});
        drv.wr(`NFQM_OFF_DRV_FEAT, ~w);
        drv.wr(`NFQM_OFF_CTRL, 32'h1);
        drv.rd(`NFQM_OFF_NEG_FEAT, rdv);
        check("neg_feat", rdv, neg);
        check("feat", {11'h0, feat},
            {11'h0, neg[23:21], neg[19:5], neg[2:0]});
        check("neg_error", {31'h0, neg_error}, {31'h0, viol != 32'h0});
        check("negotiated", {31'h0, negotiated}, 32'h1);
        check("queue_n", {rx_queue_n, tx_queue_n}, {16'(n), 16'(n)});
        check("ctrlq_port", {14'h0, ctrl_queue_present, ctrl_queue_idx},
            {14'h0, neg[17], 17'(2 * n + 2)});
        drv.rd(`NFQM_OFF_QPAIRS, rdv);
        check("qpairs", rdv, 32'(n));
        drv.rd(`NFQM_OFF_CTRLQ_IDX, rdv);
        check("ctrlq_idx", rdv, 32'(2 * n + 2));
        for (int i = 0; i < 2 * n + 4; i++) begin
            @(posedge sys_clk);
            q_index <= 17'(i);
            @(posedge sys_clk);
            #1;
            check("q_info", {14'h0, q_info}, exp_q(i, n, neg[17]));
        end
        drv.wr(`NFQM_OFF_QUERY, 32'(2 * n + 2));
        drv.rd(`NFQM_OFF_QUERY, rdv);
        check("query", rdv, exp_q(2 * n + 2, n, neg[17]));
        drv.wr(`NFQM_OFF_CTRL, 32'h4);
        drv.rd(`NFQM_OFF_STAT, rdv);
        check("stat_clear", rdv, 32'h0);
    endtask : negotiate

    initial begin
        rst = 1'h1;
        link_up = 1'h0;
        announce_req = 1'h0;
        q_index = 17'h0;
        seed = 16'h3FAA;
        repeat (4) @(posedge sys_clk);
        rst <= 1'h0;
        drv.wr(`NFQM_OFF_DEV_FEAT, 32'h0);
        drv.rd(`NFQM_OFF_DEV_FEAT, rdv);
        check("dev_feat", rdv, DEVF);
        drv.rd(`NFQM_OFF_MAX_PAIRS, rdv);
        check("max_pairs", rdv, 32'(MAXP));
        drv.rd(`NFQM_OFF_QPAIRS, rdv);
        check("qpairs_rst", rdv, 32'h1);
        drv.rd(`NFQM_OFF_CTRLQ_IDX, rdv);
        check("ctrlq_rst", rdv, 32'h4);
        drv.rd(8'h3C, rdv);
        check("unmapped", rdv, 32'h0);
        foreach (corners[i]) negotiate(corners[i], 1'(i));
        repeat (20) begin
            seed = step(seed);
            word[31:16] = seed;
            seed = step(seed);
            word[15:0] = seed;
            legacy = word[3];
            negotiate(word[4] ? drv.lawful(word) : word, legacy);
        end
        @(posedge sys_clk);
        link_up <= 1'h1;
        announce_req <= 1'h1;
        @(posedge sys_clk);
        announce_req <= 1'h0;
        drv.rd(`NFQM_OFF_LINK_STAT, rdv);
        check("link_ann", rdv, {16'h0, `NFQM_LINK_UP | `NFQM_ANNOUNCE});
        drv.wr(`NFQM_OFF_LINK_STAT, 32'h2);
        drv.rd(`NFQM_OFF_LINK_STAT, rdv);
        check("link_clr", rdv, {16'h0, `NFQM_LINK_UP});
        @(posedge sys_clk);
        link_up <= 1'h0;
        drv.rd(`NFQM_OFF_LINK_STAT, rdv);
        check("link_down", rdv, 32'h0);
        results();
    end
endmodule : tb
